// ===== dv/rf_far_side_model.sv
/*
  Behavioural far side of the frame sequencer: encoder frame timing and data line.
  Assumes one clock; the bench sets the frame length, short or long.
*/
`timescale 1ns/1ps
module rf_far_side_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_frame_enable,
  input  wire logic [7:0] i_frame_len,
  output logic            o_frame_done,
  output logic            o_mod_data
);
  // ==========================================================================
  // Frame timing
  logic [7:0] cnt_q;
  logic       sent_q;

  // One done pulse per enabled frame; a second waits for enable to drop
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      {cnt_q, sent_q, o_frame_done} <= 10'h000;
    end else begin
      o_frame_done <= 1'b0;
      if (!i_frame_enable) begin
        {cnt_q, sent_q} <= 9'h000;
      end else if (!sent_q) begin
        cnt_q <= cnt_q + 8'h01;
        if (cnt_q == i_frame_len) begin
          {o_frame_done, sent_q} <= 2'b11;
        end
      end
    end
  end

  // Data line changes every cycle so a stale bit is never mistaken for a pass
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) o_mod_data <= 1'b0;
    else o_mod_data <= ~o_mod_data;
  end
endmodule

// ===== dv/tb_rf_frame_sequencer_timing.sv
/*
  Self-checking bench of the frame sequencer: AXI4-Lite tasks, datagram runs, timing monitor.
  Assumes the tick parameter is shortened to 10 cycles.
*/
`timescale 1ns/1ps
module tb_rf_frame_sequencer_timing;
  logic        clk, rst, awv, wv, bry, arv, rry, err, lv, mclr, fe_d, irq_d, mdata_d;
  logic [7:0]  awa, ara, flen;
  logic [31:0] wd, d;
  logic [3:0]  ws;
  logic [1:0]  r;
  wire logic   awr, wr, bv, arr, rv, fe, pa, osc, vb, irq, fdone, mdata;
  wire logic [1:0]  br, rr;
  wire logic [31:0] rd;
  int fails, samples_checked, cyc, low_cnt, off_cnt, off_last, frames, irq_lat, g;
  int gaps[4];

  rf_frame_sequencer_timing #(.TICK_CYCLES(10)) DUT (.i_clk(clk), .i_rst(rst), .i_awvalid(awv),
    .i_awaddr(awa), .o_awready(awr), .i_wvalid(wv), .i_wdata(wd), .i_wstrb(ws), .o_wready(wr),
    .o_bvalid(bv), .o_bresp(br), .i_bready(bry), .i_arvalid(arv), .i_araddr(ara), .o_arready(arr),
    .o_rvalid(rv), .o_rdata(rd), .o_rresp(rr), .i_rready(rry), .i_frame_done(fdone),
    .i_mod_data(mdata), .i_tx_error(err), .i_low_voltage(lv), .o_frame_enable(fe), .o_pa_drive(pa),
    .o_osc_enable(osc), .o_vco_boost(vb), .o_irq(irq));
  rf_far_side_model FAR (.i_clk(clk), .i_rst(rst), .i_frame_enable(fe), .i_frame_len(flen),
    .o_frame_done(fdone), .o_mod_data(mdata));

  // ==========================================================================
  // Clock and monitor
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    fe_d <= fe;
    irq_d <= irq;
    mdata_d <= mdata;
    if (fe) begin
      samples_checked++;
      if (pa !== mdata_d) begin
        fails++;
        $display("wrong value pa expected %b seen %b", mdata_d, pa);
      end
    end
    low_cnt <= fe ? 0 : low_cnt + 1;
    off_cnt <= fe ? 0 : off_cnt + int'(!osc);
    if (fe && !fe_d && frames < 4) begin
      gaps[frames] <= low_cnt;
      off_last <= off_cnt;
      frames <= frames + 1;
    end
    if (irq && !irq_d) irq_lat <= low_cnt;
    if (mclr) {frames, low_cnt} <= 64'h0;
    if (cyc == 20000) begin
      fails++;
      close_out();
    end
  end

  // ==========================================================================
  // Bus and check tasks
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    {awv, wv, bry} <= 3'b111;
    {awa, wd} <= {a, v};
    forever begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
      if (bv) break;
    end
    r = br;
    bry <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a);
    @(posedge clk);
    {arv, rry} <= 2'b11;
    ara <= a;
    forever begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (rv) break;
    end
    {d, r} = {rd, rr};
    rry <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic rng(input string nm, input int lo, input int hi, input int got);
    samples_checked++;
    if (got < lo || got > hi) begin
      fails++;
      $display("wrong value %s expected %0d to %0d seen %0d", nm, lo, hi, got);
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    axr(a);
    chk("register", exp, d);
  endtask

  // One datagram: configure, send, wait for completion, then stop and acknowledge
  task automatic run(input logic [7:0] fcc, bt, sb, fnt, msk);
    axw(8'h00, {24'h0, fcc});
    axw(8'h04, {24'h0, bt});
    axw(8'h08, {24'h0, sb});
    axw(8'h0C, {24'h0, fnt});
    axw(8'h18, {24'h0, msk});
    @(posedge clk) mclr <= 1'b1;
    @(posedge clk) mclr <= 1'b0;
    axw(8'h10, 32'h1);
    d = 32'h0;
    for (int n = 0; n < 500 && d[0] !== 1'b1; n++) axr(8'h14);
    repeat (2) @(posedge clk);
    chk("completion", 32'h1, d & 32'h1);
    chk("irq", {31'h0, msk[0]}, {31'h0, irq});
    chk("frames", {28'h0, fcc[3:0]} + 1, frames);
    axw(8'h10, 32'h10);
    axr(8'h14);
    chk("flags cleared", 32'h0, d & 32'h7);
    $display("datagram test done");
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    {rst, awv, wv, bry, arv, rry, err, lv, mclr, fe_d, irq_d} = 11'h400;
    {awa, ara, wd, ws, flen} = {48'h0, 4'hF, 8'h03};
    {fails, samples_checked, cyc, irq_lat} = 128'h0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rdc(8'h00, 32'h0);
    rdc(8'h04, 32'h0);
    rdc(8'h08, 32'h0);
    axr(8'h1C);
    chk("unmapped read", 32'h2, {30'h0, r});
    axw(8'h1C, 32'hFF);
    chk("unmapped write", 32'h2, {30'h0, r});
    axw(8'h08, 32'h80);
    rdc(8'h08, 32'h80);
    chk("boost", 32'h1, {31'h0, vb});
    axw(8'h00, 32'h80);
    axw(8'h10, 32'h6);
    repeat (2) @(posedge clk);
    chk("direct high", 32'h1, {31'h0, pa});
    axw(8'h00, 32'h0);
    repeat (2) @(posedge clk);
    chk("direct low", 32'h0, {31'h0, pa});
    axw(8'h10, 32'h0);
    $display("register test done");
    run(8'h02, 8'd5, 8'h00, 8'h00, 8'h01);
    rng("start", 0, 10, gaps[0]);
    rng("gap1", 50, 55, gaps[1]);
    rng("gap2", 50, 55, gaps[2]);
    chk("osc off", 32'h0, off_last);
    rng("irq latency", 0, 4, irq_lat);
    run(8'h61, 8'd5, 8'h00, 8'h00, 8'h00);
    rng("initial delay", 50, 62, gaps[0]);
    rng("osc off gap", 37, 43, off_last);
    chk("osc stopped", 32'h0, {31'h0, osc});
    run(8'h11, 8'd5, 8'h00, 8'h00, 8'h01);
    rng("delayed flag", 50, 57, irq_lat);
    flen <= 8'd20;
    run(8'h02, 8'd7, 8'h00, 8'h05, 8'h00);
    rng("max gap1", 70, 75, gaps[1]);
    rng("max gap2", 100, 105, gaps[2]);
    run(8'h01, 8'd5, 8'h01, 8'h00, 8'h00);
    g = gaps[1];
    rng("random gap", 60, 1330, g);
    run(8'h01, 8'd5, 8'h01, 8'h00, 8'h00);
    chk("seed reload", g, gaps[1]);
    @(posedge clk) {err, lv} <= 2'b11;
    repeat (3) @(posedge clk);
    {err, lv} <= 2'b00;
    repeat (8) @(posedge clk);
    rdc(8'h14, 32'h6);
    axw(8'h10, 32'h10);
    rdc(8'h14, 32'h0);
    axw(8'h00, 32'h7F);
    axw(8'h04, 32'h05);
    axw(8'h08, 32'hFF);
    axw(8'h10, 32'h08);
    rdc(8'h00, 32'h0);
    rdc(8'h04, 32'h0);
    rdc(8'h08, 32'h0);
    rdc(8'h10, 32'h0);
    chk("boost cleared", 32'h0, {31'h0, vb});
    $display("soft reset test done");
    close_out();
  end
endmodule

// ===== src/rf_frame_sequencer_timing.sv
/*
  Frame sequencer and interframe timer of the radio transmitter module, with an AXI4-Lite
  register slave, sticky event flags and one level interrupt.
  Assumes the encoder pulses i_frame_done on i_clk, i_mod_data is on i_clk, and the error
  and low-voltage inputs come from pins outside the clock domain.
*/
// Added by the designer: the address map and the AXI4-Lite slave port.
// Contract
// RL1 - Direct mode (coding 11) drives amplifier output from the direct data bit
// RL2 - Oscillator on while sending; powered down in interframe gaps when power-down set
// RL3 - With power-down, restart analog blocks 1 ms before gap ends if frames remain
// RL4 - Initial random space inserts a delay before first frame; else start at once
// RL5 - Completion flag after last frame, or after one more gap when delay bit set
// RL6 - Completion raises the interrupt only when the transmitter interrupt enable is set
// RL7 - Frames per datagram equal frame count plus one, randomly spaced
// RL8 - Module reset clears all control fields of the three registers
// RL9 - Base delay is base timer counts of one millisecond
// RL10 - Software writes base timer only as zero or 5 to 255
// RL11 - Boost selects higher VCO power when set, lower when cleared
// RL12 - Seed copied into the shift register when send request becomes set
// RL13 - Random delay is shift value in ms, only with a nonzero seed
// RL14 - Zero shift register stays zero; nonzero steps through the sequence
// RL15 - Without random seed, base and frame-number timers run together: larger wins
// RL16 - Frame-number delay is its field in ms times the last frame number
// RL17 - Soft reset bit resets module and registers, always reads zero
// RL18 - Acknowledge write clears completion, error and low-voltage flags
// RL19 - Shift register is 7-bit maximal length, advanced once per interval
`timescale 1ns/1ps
`include "rf_seq_params.svh"

module rf_frame_sequencer_timing import rf_seq_pkg::*; #(
  parameter int TICK_CYCLES = `RFS_TICK_CYCLES,
  parameter int AW          = 8
) (
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  input  wire logic          i_awvalid,
  input  wire logic [AW-1:0] i_awaddr,
  output logic               o_awready,
  input  wire logic          i_wvalid,
  input  wire logic [31:0]   i_wdata,
  input  wire logic [3:0]    i_wstrb,
  output logic               o_wready,
  output logic               o_bvalid,
  output logic [1:0]         o_bresp,
  input  wire logic          i_bready,
  input  wire logic          i_arvalid,
  input  wire logic [AW-1:0] i_araddr,
  output logic               o_arready,
  output logic               o_rvalid,
  output logic [31:0]        o_rdata,
  output logic [1:0]         o_rresp,
  input  wire logic          i_rready,
  input  wire logic          i_frame_done,
  input  wire logic          i_mod_data,
  input  wire logic          i_tx_error,
  input  wire logic          i_low_voltage,
  output logic               o_frame_enable,
  output logic               o_pa_drive,
  output logic               o_osc_enable,
  output logic               o_vco_boost,
  output logic               o_irq
);

  localparam int TW = $clog2(TICK_CYCLES + 1);

  // ===========================================================================
  // Register state
  frame_ctrl_s fcc_q;
  seed_boost_s sbr_q;
  logic [7:0]  base_q;
  logic [5:0]  fnt_q;
  logic        send_q;
  logic [1:0]  code_q;
  logic        soft_rst_q;
  logic [2:0]  stat_q;
  logic [2:0]  mask_q;

  // Bus state
  logic          aw_got_q;
  logic          w_got_q;
  logic [AW-1:0] awaddr_q;
  logic [31:0]   wdata_q;
  logic          wstrb0_q;
  logic          wr_do;
  logic          wr_ok;
  logic          wr_ctl;

  // Sequencer state
  seq_state_e    state_q;
  logic          send_prev_q;
  logic          start;
  logic [6:0]    lfsr_q;
  logic [4:0]    sent_q;
  logic          tail_q;
  logic [11:0]   gap_q;
  logic [TW-1:0] tick_cnt_q;
  logic          tick;
  logic          done_evt;

  // ===========================================================================
  // AXI4-Lite write channel
  assign wr_do  = aw_got_q && w_got_q && !o_bvalid;
  assign wr_ok  = (awaddr_q == `RFS_OFF_FRAME_COUNT_CONTROL) || (awaddr_q == `RFS_OFF_BASE_INTERFRAME) ||
                  (awaddr_q == `RFS_OFF_SEED_BOOST) || (awaddr_q == `RFS_OFF_FRAME_NUMBER_TIMER) ||
                  (awaddr_q == `RFS_OFF_CONTROL) || (awaddr_q == `RFS_OFF_STATUS) ||
                  (awaddr_q == `RFS_OFF_IRQ_MASK);
  assign wr_ctl = wr_do && wstrb0_q && (awaddr_q == `RFS_OFF_CONTROL);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_awready <= 1'b1;
      o_wready  <= 1'b1;
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= 32'h0000_0000;
      wstrb0_q  <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= `RFS_RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        o_awready <= 1'b0;
        aw_got_q  <= 1'b1;
        awaddr_q  <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        o_wready <= 1'b0;
        w_got_q  <= 1'b1;
        wdata_q  <= i_wdata;
        wstrb0_q <= i_wstrb[0];
      end
      if (wr_do) begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp  <= wr_ok ? `RFS_RESP_OKAY : `RFS_RESP_SLVERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid  <= 1'b0;
        o_awready <= 1'b1;
        o_wready  <= 1'b1;
      end
    end
  end

  // ===========================================================================
  // Configuration registers; only byte lane 0 carries data
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      fcc_q  <= `RFS_RST_BYTE;
      base_q <= `RFS_RST_BYTE;
      sbr_q  <= `RFS_RST_BYTE;
      fnt_q  <= `RFS_RST_FNT;
      mask_q <= `RFS_RST_MASK;
      send_q <= 1'b0;
      code_q <= 2'h0;
    end else if (soft_rst_q) begin
      fcc_q  <= `RFS_RST_BYTE; // RL8 RL17
      base_q <= `RFS_RST_BYTE;
      sbr_q  <= `RFS_RST_BYTE;
      fnt_q  <= `RFS_RST_FNT;
      mask_q <= `RFS_RST_MASK;
      send_q <= 1'b0;
      code_q <= 2'h0;
    end else if (wr_do && wstrb0_q) begin
      if (awaddr_q == `RFS_OFF_FRAME_COUNT_CONTROL) begin
        fcc_q <= wdata_q[7:0];
      end else if (awaddr_q == `RFS_OFF_BASE_INTERFRAME) begin
        base_q <= wdata_q[7:0]; // RL10
      end else if (awaddr_q == `RFS_OFF_SEED_BOOST) begin
        sbr_q <= wdata_q[7:0];
      end else if (awaddr_q == `RFS_OFF_FRAME_NUMBER_TIMER) begin
        fnt_q <= wdata_q[5:0];
      end else if (awaddr_q == `RFS_OFF_CONTROL) begin
        send_q <= wdata_q[`RFS_CTL_SEND];
        code_q <= wdata_q[`RFS_CTL_CODE_HI:`RFS_CTL_CODE_LO];
      end else if (awaddr_q == `RFS_OFF_IRQ_MASK) begin
        mask_q <= wdata_q[2:0];
      end
    end
  end

  // Soft reset is a one-cycle pulse; processor reset only clears the pulse itself
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= wr_ctl && wdata_q[`RFS_CTL_SOFT_RST]; // RL17
    end
  end

  // ===========================================================================
  // AXI4-Lite read channel
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= `RFS_RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b1;
      o_rresp   <= `RFS_RESP_OKAY;
      o_rdata   <= 32'h0000_0000;
      if (i_araddr == `RFS_OFF_FRAME_COUNT_CONTROL) begin
        o_rdata[7:0] <= fcc_q;
      end else if (i_araddr == `RFS_OFF_BASE_INTERFRAME) begin
        o_rdata[7:0] <= base_q;
      end else if (i_araddr == `RFS_OFF_SEED_BOOST) begin
        o_rdata[7:0] <= sbr_q;
      end else if (i_araddr == `RFS_OFF_FRAME_NUMBER_TIMER) begin
        o_rdata[5:0] <= fnt_q;
      end else if (i_araddr == `RFS_OFF_CONTROL) begin
        o_rdata[2:0] <= {code_q, send_q}; // RL17
      end else if (i_araddr == `RFS_OFF_STATUS) begin
        o_rdata[4:0] <= {o_osc_enable, state_q != ST_IDLE, stat_q};
      end else if (i_araddr == `RFS_OFF_IRQ_MASK) begin
        o_rdata[2:0] <= mask_q;
      end else begin
        o_rresp <= `RFS_RESP_SLVERR;
      end
    end else if (o_rvalid && i_rready) begin
      o_rvalid  <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  // ===========================================================================
  // Pin synchronisers: a level is accepted once the second and third stages agree
  logic [1:0] pin_s1_q;
  logic [1:0] pin_s2_q;
  logic [1:0] pin_s3_q;
  logic [1:0] pin_lvl_q;
  logic [1:0] pin_rise;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_s1_q  <= 2'h0;
      pin_s2_q  <= 2'h0;
      pin_s3_q  <= 2'h0;
      pin_lvl_q <= 2'h0;
    end else begin
      pin_s1_q <= {i_low_voltage, i_tx_error};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      for (int i = 0; i < 2; i++) begin
        if (pin_s2_q[i] == pin_s3_q[i]) begin
          pin_lvl_q[i] <= pin_s3_q[i];
        end
      end
    end
  end

  assign pin_rise = pin_s2_q & pin_s3_q & ~pin_lvl_q;

  // ===========================================================================
  // Sticky flags; a new event wins over a clear in the same cycle
  logic [2:0] evt;
  logic [2:0] clr;

  assign evt = {pin_rise, done_evt};
  assign clr = (wr_do && wstrb0_q && awaddr_q == `RFS_OFF_STATUS) ? wdata_q[2:0] :
               (wr_ctl && wdata_q[`RFS_CTL_ACK]) ? 3'h7 : 3'h0; // RL18

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      stat_q <= 3'h0;
      o_irq  <= 1'b0;
    end else if (soft_rst_q) begin
      stat_q <= 3'h0;
      o_irq  <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~clr) | evt; // RL18
      o_irq  <= |(stat_q & mask_q); // RL6
    end
  end

  // ===========================================================================
  // Millisecond tick, restarted at each gap so the first count is a full one
  assign tick = (tick_cnt_q == TW'(TICK_CYCLES - 1));

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tick_cnt_q <= '0;
    end else if (state_q != ST_GAP || tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + TW'(1);
    end
  end

  // ===========================================================================
  // Interval length in ms for the gap that follows frame number sent_q + 1
  logic [10:0] fnt_prod;
  logic [11:0] gap_ms;
  logic        rand_on;
  logic        last_frame;

  // Frame number of the frame just finished is one more than the frames counted before it
  assign fnt_prod   = 11'(fnt_q) * 11'(sent_q + 5'h01); // RL16
  assign rand_on    = (sbr_q.random_seed != 7'h00); // RL13
  assign last_frame = ((sent_q + 5'h01) == ({1'b0, fcc_q.frame_count} + 5'h01)); // RL7

  always_comb begin
    if (rand_on) begin
      gap_ms = 12'(base_q) + 12'(lfsr_q) + 12'(fnt_prod); // RL9 RL13
    end else if (12'(base_q) > 12'(fnt_prod)) begin
      gap_ms = 12'(base_q); // RL15
    end else begin
      gap_ms = 12'(fnt_prod);
    end
  end

  // ===========================================================================
  // Sequencer
  assign start    = send_q && !send_prev_q;
  assign done_evt = (state_q == ST_SEND && i_frame_done && last_frame && !fcc_q.interframe_irq_delay) ||
                    (state_q == ST_GAP && tail_q && gap_q == 12'h000); // RL5

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q     <= ST_IDLE;
      send_prev_q <= 1'b0;
      sent_q      <= 5'h00;
      tail_q      <= 1'b0;
      gap_q       <= 12'h000;
    end else begin
      send_prev_q <= send_q;
      if (!send_q || soft_rst_q) begin
        state_q <= ST_IDLE;
      end else begin
        case (state_q)
          ST_IDLE: begin
            sent_q <= 5'h00;
            tail_q <= 1'b0;
            if (start && fcc_q.initial_random_space) begin
              state_q <= ST_GAP; // RL4
              gap_q   <= 12'(base_q) + (rand_on ? 12'(sbr_q.random_seed) : 12'h000);
            end else if (start) begin
              state_q <= ST_SEND; // RL4
            end
          end
          ST_SEND: begin
            if (i_frame_done) begin
              sent_q <= sent_q + 5'h01;
              if (last_frame && !fcc_q.interframe_irq_delay) begin
                state_q <= ST_DONE;
              end else begin
                state_q <= ST_GAP;
                tail_q  <= last_frame; // RL5
                gap_q   <= gap_ms;
              end
            end
          end
          ST_GAP: begin
            if (gap_q == 12'h000) begin
              state_q <= tail_q ? ST_DONE : ST_SEND;
            end else if (tick) begin
              gap_q <= gap_q - 12'h001;
            end
          end
          ST_DONE: begin
            state_q <= ST_DONE;
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Seed copy on send; x^7 + x^6 + 1 stepped at each frame done in ST_SEND, zero is a fixed point
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      lfsr_q <= 7'h00;
    end else if (soft_rst_q) begin
      lfsr_q <= 7'h00;
    end else if (start) begin
      lfsr_q <= sbr_q.random_seed; // RL12
    end else if (state_q != ST_GAP && state_q != ST_IDLE && state_q != ST_DONE && i_frame_done) begin
      lfsr_q <= {lfsr_q[5:0], lfsr_q[6] ^ lfsr_q[5]}; // RL14 RL19
    end
  end

  // ===========================================================================
  // Analog controls, all registered: enables one cycle behind the sequencer state, boost from its register bit
  logic osc_d;

  assign osc_d = send_q && !(fcc_q.interframe_power_down && state_q == ST_GAP &&
                             !(!tail_q && gap_q <= 12'h001)); // RL2 RL3

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_osc_enable   <= 1'b0;
      o_frame_enable <= 1'b0;
      o_pa_drive     <= 1'b0;
      o_vco_boost    <= 1'b0;
    end else begin
      o_osc_enable   <= osc_d;
      o_frame_enable <= (state_q == ST_SEND);
      o_vco_boost    <= sbr_q.boost; // RL11
      if (code_q == `RFS_CODE_DIRECT) begin
        o_pa_drive <= fcc_q.direct_data; // RL1
      end else begin
        o_pa_drive <= (state_q == ST_SEND) && i_mod_data;
      end
    end
  end

  // ===========================================================================
  // Checks
  a_direct_pa_data : assert property (@(posedge i_clk) disable iff (i_rst)
    (code_q == `RFS_CODE_DIRECT) |=> (o_pa_drive == $past(fcc_q.direct_data))) // RL1
    else $error("direct mode output does not follow data bit");

  a_osc_held_on : assert property (@(posedge i_clk) disable iff (i_rst)
    (send_q && !fcc_q.interframe_power_down) |=> o_osc_enable) // RL2
    else $error("oscillator dropped while sending without power-down");

  a_osc_gap_down : assert property (@(posedge i_clk) disable iff (i_rst)
    (state_q == ST_GAP && fcc_q.interframe_power_down && gap_q > 12'h001) |=> !o_osc_enable) // RL2
    else $error("oscillator on during powered-down gap");

  a_osc_restart_early : assert property (@(posedge i_clk) disable iff (i_rst)
    (send_q && state_q == ST_GAP && !tail_q && gap_q == 12'h001) |=> o_osc_enable) // RL3
    else $error("oscillator not restarted in last millisecond");

  a_no_initial_gap : assert property (@(posedge i_clk) disable iff (i_rst)
    (state_q == ST_IDLE && start && !fcc_q.initial_random_space && !soft_rst_q) |=> state_q == ST_SEND) // RL4
    else $error("first frame delayed without initial space");

  a_flag_after_last : assert property (@(posedge i_clk) disable iff (i_rst)
    (state_q == ST_SEND && send_q && !soft_rst_q && i_frame_done && last_frame &&
     !fcc_q.interframe_irq_delay) |=> stat_q[`RFS_ST_DONE]) // RL5
    else $error("completion flag missing after last frame");

  a_irq_gated : assert property (@(posedge i_clk) disable iff (i_rst)
    (!soft_rst_q && stat_q[`RFS_ST_DONE] && !mask_q[`RFS_ST_DONE] && stat_q[2:1] == 2'h0) |=> !o_irq) // RL6
    else $error("interrupt raised without enable");

  a_seed_load : assert property (@(posedge i_clk) disable iff (i_rst)
    (start && !soft_rst_q) |=> (lfsr_q == $past(sbr_q.random_seed))) // RL12
    else $error("seed not copied on send");

  a_lfsr_zero_hold : assert property (@(posedge i_clk) disable iff (i_rst)
    (lfsr_q == 7'h00 && !start) |=> (lfsr_q == 7'h00)) // RL14
    else $error("zero shift register left zero");

  a_soft_reset_clear : assert property (@(posedge i_clk) disable iff (i_rst)
    soft_rst_q |=> (fcc_q == 8'h00 && base_q == 8'h00 && sbr_q == 8'h00 && fnt_q == 6'h00)) // RL8
    else $error("soft reset left fields set");

  c_datagram_done : cover property (@(posedge i_clk) disable iff (i_rst) done_evt);
  c_powered_gap   : cover property (@(posedge i_clk) disable iff (i_rst)
    state_q == ST_GAP && !o_osc_enable);
  c_tail_gap      : cover property (@(posedge i_clk) disable iff (i_rst) state_q == ST_GAP && tail_q);

endmodule

// ===== src/rf_seq_params.svh
/*
  Register offsets, field positions, reset values and timing figures of the frame sequencer.
  Assumes it is included by its bare name next to rf_seq_pkg.
*/
`ifndef RF_SEQ_PARAMS_SVH
`define RF_SEQ_PARAMS_SVH

// ===========================================================================
// Register byte offsets
`define RFS_OFF_FRAME_COUNT_CONTROL 8'h00
`define RFS_OFF_BASE_INTERFRAME     8'h04
`define RFS_OFF_SEED_BOOST          8'h08
`define RFS_OFF_FRAME_NUMBER_TIMER  8'h0C
`define RFS_OFF_CONTROL             8'h10
`define RFS_OFF_STATUS              8'h14
`define RFS_OFF_IRQ_MASK            8'h18

// ===========================================================================
// Control register fields
`define RFS_CTL_SEND       0
`define RFS_CTL_CODE_LO    1
`define RFS_CTL_CODE_HI    2
`define RFS_CTL_SOFT_RST   3
`define RFS_CTL_ACK        4
`define RFS_CODE_DIRECT    2'h3

// Status and mask fields
`define RFS_ST_DONE        0
`define RFS_ST_ERR         1
`define RFS_ST_LV          2
`define RFS_ST_BUSY        3
`define RFS_ST_OSC         4
`define RFS_NUM_EVENTS     3

// ===========================================================================
// Reset values
`define RFS_RST_BYTE       8'h00
`define RFS_RST_FNT        6'h00
`define RFS_RST_MASK       3'h0

// ===========================================================================
// Timing
`define RFS_CLK_PERIOD_NS  10
`define RFS_TICK_NS        1000000
`define RFS_TICK_CYCLES    (`RFS_TICK_NS / `RFS_CLK_PERIOD_NS)

// AXI responses
`define RFS_RESP_OKAY      2'h0
`define RFS_RESP_SLVERR    2'h2

`endif

// ===== src/rf_seq_pkg.sv
/*
  Types shared by the frame sequencer: sequence states and the packed control and seed/boost bytes.
  Assumes rf_seq_params.svh holds the numeric constants.
*/
package rf_seq_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SEND = 3'b001,
    ST_GAP  = 3'b010,
    ST_DONE = 3'b011
  } seq_state_e;

  typedef struct packed {
    logic       direct_data;
    logic       interframe_power_down;
    logic       initial_random_space;
    logic       interframe_irq_delay;
    logic [3:0] frame_count;
  } frame_ctrl_s;

  typedef struct packed {
    logic       boost;
    logic [6:0] random_seed;
  } seed_boost_s;

endpackage
